// *** core/dca_cmd_decode.sv ***
// dca_cmd_decode: command code decode from rank select and the three strobes
`timescale 1ns/1ns
`default_nettype none
module dca_cmd_decode
   import dca_pkg::*;
(
   // command strobes, active low
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   // decoded commands
   output logic is_act,
   output logic is_rd,
   output logic is_wr,
   output logic is_pre,
   output logic is_mrs,
   output logic is_ref
);
   logic [3:0] code;

   // rank select is the top bit of the code, so a deselect matches nothing
   always_comb begin
      code = {cs_n, ras_n, cas_n, we_n};
      is_act = (code == CMD_ACTIVATE);
      is_rd = (code == CMD_READ);
      is_wr = (code == CMD_WRITE);
      is_pre = (code == CMD_PRECHARGE);
      is_mrs = (code == CMD_MODE_LOAD);
      is_ref = (code == CMD_REFRESH);
   end
endmodule // dca_cmd_decode
`default_nettype wire

// *** core/dca_decoder.sv ***
// dca_decoder: command and address decode with write mask sampling
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module dca_decoder (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RESETN,
   // axi4-lite write channels
   input wire logic [dca_pkg::AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // axi4-lite read channels
   input wire logic [dca_pkg::AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // command and address pins
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [dca_pkg::BANK_W-1:0] GROUP_INDEX,
   input wire logic [dca_pkg::ADDR_W-1:0] ADDR_LINES,
   input wire logic CLK_GATE,
   input wire logic TERMINATION_ENABLE,
   // write mask pins
   input wire logic WRITE_MASK,
   input wire logic DATA_STROBE,
   // decoded commands, one-cycle pulses
   output logic CMD_ACT,
   output logic CMD_READ,
   output logic CMD_WRITE,
   output logic CMD_PRE,
   output logic CMD_MODE_LOAD,
   output logic CMD_REFRESH,
   // captured fields
   output logic [dca_pkg::BANK_W-1:0] CMD_BANK,
   output logic [dca_pkg::ADDR_W-1:0] ROW_ADDR,
   output logic [dca_pkg::ADDR_W-1:0] COL_ADDR,
   output logic AUTO_PRECHARGE,
   output logic PRECHARGE_ALL,
   output logic CHOP_FLAG,
   output logic [dca_pkg::BANK_W-1:0] MODE_SEL,
   output logic [dca_pkg::ADDR_W-1:0] MODE_OPCODE,
   // write beats and status
   output logic BEAT_VALID,
   output logic BEAT_KEEP,
   output logic TERM_STROBE_MODE,
   output logic TERM_ACTIVE,
   output logic [2:0] POWER_STATE
);
   import dca_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisation and decode
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] s_pins;
   logic s_cs_n, s_ras_n, s_cas_n, s_we_n, s_cke, s_odt, s_mask, s_dqs;
   logic [BANK_W-1:0] s_gi;
   logic [ADDR_W-1:0] s_addr;
   logic is_act, is_rd, is_wr, is_pre, is_mrs, is_ref;

   dca_sync #(.WIDTH(PIN_W), .INIT(PIN_INIT)) u_sync (
      .clk(CORE_CLK),
      .rst_n(RESETN),
      .din({CS_N, RAS_N, CAS_N, WE_N, GROUP_INDEX, ADDR_LINES, CLK_GATE,
            TERMINATION_ENABLE, WRITE_MASK, DATA_STROBE}),
      .dout(s_pins)
   );
   // unpack the synchronised pins
   assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_gi, s_addr, s_cke, s_odt, s_mask, s_dqs} = s_pins;

   dca_cmd_decode u_dec (
      .cs_n(s_cs_n),
      .ras_n(s_ras_n),
      .cas_n(s_cas_n),
      .we_n(s_we_n),
      .is_act(is_act),
      .is_rd(is_rd),
      .is_wr(is_wr),
      .is_pre(is_pre),
      .is_mrs(is_mrs),
      .is_ref(is_ref)
   );

   // ----------------------------------------------------------------
   // decode state
   // ----------------------------------------------------------------
   dca_pwr_t pwr, next_pwr;
   logic ctrl_en, next_ctrl_en;
   logic [31:0] count, next_count;
   logic [ADDR_W-1:0] mode_reg [NUM_MODE_REGS];
   logic [ADDR_W-1:0] next_mode_reg [NUM_MODE_REGS];
   logic [5:0] cmd, next_cmd;
   logic [BANK_W-1:0] bank, next_bank, msel, next_msel;
   logic [ADDR_W-1:0] row, next_row, col, next_col, opcode, next_opcode;
   logic ap, next_ap, pall, next_pall, chop, next_chop;
   logic [3:0] beats, next_beats;
   logic dqs_q, bvld, next_bvld, bkeep, next_bkeep, term, next_term;
   logic go, dqs_edge, beat_go, termination_strobe_mode, wr_hit;
   logic [31:0] wd;

   // sampling gate: only an awake, enabled device with clock gate high decodes
   assign go = (pwr == PWR_ON) && s_cke && ctrl_en;
   assign dqs_edge = s_dqs ^ dqs_q;
   assign beat_go = dqs_edge && (beats != '0) && (pwr == PWR_ON);
   assign termination_strobe_mode = mode_reg[MODE_REG_ONE][TERMINATION_STROBE_SEL_BIT];

   // next values of the command, capture, mask and power state
   always_comb begin
      next_cmd = '0;
      next_bank = bank;
      next_row = row;
      next_col = col;
      next_ap = ap;
      next_pall = pall;
      next_chop = chop;
      next_msel = msel;
      next_opcode = opcode;
      next_mode_reg = mode_reg;
      next_count = count;
      next_beats = beats;
      next_bvld = 1'b0;
      next_bkeep = bkeep;
      next_pwr = pwr;
      // deselect or sleep yields no command at all
      if (go) begin
         next_cmd = {is_ref, is_mrs, is_pre, is_wr, is_rd, is_act};
         if (is_act || is_rd || is_wr || is_pre) begin
            next_bank = s_gi;
         end
         if (is_act) begin
            next_row = s_addr;
         end
         if (is_rd || is_wr) begin
            next_col = s_addr;
            next_ap = s_addr[PRECHARGE_BIT];
            next_chop = s_addr[CHOP_BIT];
         end
         if (is_pre) begin
            next_pall = s_addr[PRECHARGE_BIT];
         end
         if (is_mrs) begin
            next_msel = s_gi;
            next_opcode = s_addr;
            if (32'(s_gi) < NUM_MODE_REGS) begin
               next_mode_reg[s_gi[1:0]] = s_addr;
            end
         end
         if (is_act || is_rd || is_wr || is_pre || is_mrs || is_ref) begin
            next_count = count + 32'h0000_0001;
         end
      end
      // one mask bit per strobe edge while a write burst is open
      if (beat_go) begin
         next_bvld = 1'b1;
         next_bkeep = termination_strobe_mode || !s_mask;
         next_beats = beats - 4'h1;
      end
      // a new write restarts the beat count, winning over a beat
      if (go && is_wr) begin
         next_beats = 4'(BURST_BEATS);
      end
      // sleep states follow the clock gate level
      case (pwr)
         PWR_ON: begin
            if (!s_cke) begin
               next_pwr = (is_ref && ctrl_en) ? PWR_SREF : PWR_DOWN;
               next_beats = '0;
            end
         end
         PWR_DOWN, PWR_SREF: begin
            if (s_cke) begin
               next_pwr = PWR_ON;
            end
         end
         default: next_pwr = PWR_ON;
      endcase
      // termination input stays alive in power down, not in self refresh
      next_term = s_odt && (pwr != PWR_SREF);
      next_ctrl_en = ctrl_en;
      if (wr_hit) begin
         next_ctrl_en = wd[CTRL_EN_BIT];
      end
   end

   // register the decode state
   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         pwr <= PWR_ON;
         ctrl_en <= CTRL_EN_RESET;
         count <= '0;
         mode_reg <= '{default: '0};
         cmd <= '0;
         bank <= '0;
         row <= '0;
         col <= '0;
         ap <= 1'b0;
         pall <= 1'b0;
         chop <= 1'b0;
         msel <= '0;
         opcode <= '0;
         beats <= '0;
         dqs_q <= 1'b0;
         bvld <= 1'b0;
         bkeep <= 1'b0;
         term <= 1'b0;
      end else begin
         pwr <= next_pwr;
         ctrl_en <= next_ctrl_en;
         count <= next_count;
         mode_reg <= next_mode_reg;
         cmd <= next_cmd;
         bank <= next_bank;
         row <= next_row;
         col <= next_col;
         ap <= next_ap;
         pall <= next_pall;
         chop <= next_chop;
         msel <= next_msel;
         opcode <= next_opcode;
         beats <= next_beats;
         dqs_q <= s_dqs;
         bvld <= next_bvld;
         bkeep <= next_bkeep;
         term <= next_term;
      end
   end

   // outputs straight from flip-flops
   assign {CMD_REFRESH, CMD_MODE_LOAD, CMD_PRE, CMD_WRITE, CMD_READ, CMD_ACT} = cmd;
   assign CMD_BANK = bank;
   assign ROW_ADDR = row;
   assign COL_ADDR = col;
   assign AUTO_PRECHARGE = ap;
   assign PRECHARGE_ALL = pall;
   assign CHOP_FLAG = chop;
   assign MODE_SEL = msel;
   assign MODE_OPCODE = opcode;
   assign BEAT_VALID = bvld;
   assign BEAT_KEEP = bkeep;
   assign TERM_STROBE_MODE = termination_strobe_mode;
   assign TERM_ACTIVE = term;
   assign POWER_STATE = pwr;

   // ----------------------------------------------------------------
   // axi4-lite slave, one write and one read in flight
   // ----------------------------------------------------------------
   logic aw_got, next_aw_got, w_got, next_w_got, awr, next_awr, wr_r, next_wr_r;
   logic bv, next_bv, arr, next_arr, rv, next_rv;
   logic [AXI_AW-1:0] wa, next_wa;
   logic [31:0] next_wd, rd, next_rd;
   logic [3:0] ws, next_ws;
   logic [1:0] br, next_br, rr, next_rr;

   // write applies once both halves are held; ctrl takes byte lane 0
   assign wr_hit = aw_got && w_got && !bv && (wa == REG_CTRL) && ws[0];

   always_comb begin
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_wa = wa;
      next_wd = wd;
      next_ws = ws;
      next_bv = bv;
      next_br = br;
      next_rv = rv;
      next_rd = rd;
      next_rr = rr;
      if (S_AXI_AWVALID && awr) begin
         next_aw_got = 1'b1;
         next_wa = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && wr_r) begin
         next_w_got = 1'b1;
         next_wd = S_AXI_WDATA;
         next_ws = S_AXI_WSTRB;
      end
      if (aw_got && w_got && !bv) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bv = 1'b1;
         // mapped but read-only words take the write silently
         if (wa == REG_CTRL || wa == REG_STATUS || wa == REG_LAST || wa == REG_COUNT) begin
            next_br = RESP_OKAY;
         end else if (wa[7:4] == REG_MODE_BASE[7:4] && wa[1:0] == 2'h0) begin
            next_br = RESP_OKAY;
         end else begin
            next_br = RESP_SLVERR;
         end
      end else if (bv && S_AXI_BREADY) begin
         next_bv = 1'b0;
      end
      if (S_AXI_ARVALID && arr) begin
         next_rv = 1'b1;
         next_rr = RESP_OKAY;
         next_rd = '0;
         if (S_AXI_ARADDR == REG_CTRL) begin
            next_rd[CTRL_EN_BIT] = ctrl_en;
         end else if (S_AXI_ARADDR == REG_STATUS) begin
            next_rd[2:0] = pwr;
            next_rd[ST_TERMINATION_STROBE_BIT] = termination_strobe_mode;
            next_rd[ST_TERM_BIT] = term;
            next_rd[ST_BUSY_BIT] = (beats != '0);
         end else if (S_AXI_ARADDR == REG_LAST) begin
            next_rd[ADDR_W-1:0] = row;
            next_rd[LAST_BANK_LSB +: BANK_W] = bank;
         end else if (S_AXI_ARADDR == REG_COUNT) begin
            next_rd = count;
         end else if (S_AXI_ARADDR[7:4] == REG_MODE_BASE[7:4] && S_AXI_ARADDR[1:0] == 2'h0) begin
            next_rd = 32'(mode_reg[S_AXI_ARADDR[3:2]]);
         end else begin
            next_rr = RESP_SLVERR;
         end
      end else if (rv && S_AXI_RREADY) begin
         next_rv = 1'b0;
      end
      // readies fall while a half is held or an answer waits
      next_awr = !next_aw_got && !next_bv;
      next_wr_r = !next_w_got && !next_bv;
      next_arr = !next_rv;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESETN) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         awr <= 1'b0;
         wr_r <= 1'b0;
         arr <= 1'b0;
         wa <= '0;
         wd <= '0;
         ws <= '0;
         bv <= 1'b0;
         br <= RESP_OKAY;
         rv <= 1'b0;
         rd <= '0;
         rr <= RESP_OKAY;
      end else begin
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         awr <= next_awr;
         wr_r <= next_wr_r;
         arr <= next_arr;
         wa <= next_wa;
         wd <= next_wd;
         ws <= next_ws;
         bv <= next_bv;
         br <= next_br;
         rv <= next_rv;
         rd <= next_rd;
         rr <= next_rr;
      end
   end

   assign S_AXI_AWREADY = awr;
   assign S_AXI_WREADY = wr_r;
   assign S_AXI_BVALID = bv;
   assign S_AXI_BRESP = br;
   assign S_AXI_ARREADY = arr;
   assign S_AXI_RVALID = rv;
   assign S_AXI_RDATA = rd;
   assign S_AXI_RRESP = rr;

   // ----------------------------------------------------------------
   // assertions and covers
   // ----------------------------------------------------------------
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   a_deselect_ignored: assert property (s_cs_n |=> cmd == '0)
      else $error("command decoded while rank select high");
   a_activate_code: assert property (go && !s_ras_n && s_cas_n && s_we_n && !s_cs_n
      |=> CMD_ACT && !CMD_READ && !CMD_WRITE)
      else $error("activate code not decoded");
   a_row_capture: assert property (go && is_act |=> ROW_ADDR == $past(s_addr))
      else $error("row address not captured on activate");
   a_bank_select: assert property (go && (is_act || is_rd || is_wr || is_pre)
      |=> CMD_BANK == $past(s_gi))
      else $error("bank not taken from group index");
   a_auto_precharge: assert property (go && (is_rd || is_wr)
      |=> AUTO_PRECHARGE == $past(s_addr[PRECHARGE_BIT]) && COL_ADDR == $past(s_addr))
      else $error("auto precharge or column capture wrong");
   a_precharge_all: assert property (go && is_pre
      |=> CMD_PRE && PRECHARGE_ALL == $past(s_addr[PRECHARGE_BIT]))
      else $error("precharge scope wrong");
   a_mode_select: assert property (go && is_mrs && s_gi == 3'h1
      |=> MODE_SEL == 3'h1 ##1 mode_reg[1] == $past(s_addr, 2))
      else $error("mode register select wrong");
   a_mode_opcode: assert property (go && is_mrs |=> MODE_OPCODE == $past(s_addr))
      else $error("mode op-code not captured");
   a_mask_discard: assert property (beat_go && s_mask && !termination_strobe_mode
      |=> BEAT_VALID && !BEAT_KEEP)
      else $error("masked beat was kept");
   a_strobe_mode: assert property (beat_go && termination_strobe_mode |=> BEAT_VALID && BEAT_KEEP)
      else $error("termination strobe mode masked a beat");
   a_beat_edge: assert property (BEAT_VALID |-> $past(dqs_edge))
      else $error("beat without a strobe edge");
   a_sleep_gate: assert property (pwr != PWR_ON |=> cmd == '0)
      else $error("command decoded while asleep");
   a_sref_term: assert property (pwr == PWR_SREF |=> !TERM_ACTIVE)
      else $error("termination alive in self refresh");
   a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped early");

   c_activate: cover property (go && is_act ##1 CMD_ACT);
   c_masked_beat: cover property (BEAT_VALID && !BEAT_KEEP);
   c_self_refresh: cover property (pwr == PWR_ON ##1 pwr == PWR_SREF);
   c_mode_one_load: cover property (CMD_MODE_LOAD && MODE_SEL == 3'h1);
endmodule // dca_decoder
`default_nettype wire

// *** core/dca_pkg.sv ***
// dca_pkg: shared constants and types of the command and address decoder
package dca_pkg;
   // ----------------------------------------------------------------
   // pin widths and command codes {rank select, row, column, write}
   // ----------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int BANK_W = 3;
   localparam int PIN_W = 26;
   localparam logic [3:0] CMD_MODE_LOAD = 4'h0;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_ACTIVATE = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_READ = 4'h5;
   // strobes and clock gate idle high, everything else low, until the pins are seen;
   // a low gate here would drop the block into power down right after reset
   localparam logic [PIN_W-1:0] PIN_INIT = 26'h3c0_0008;
   // ----------------------------------------------------------------
   // address bit roles and mode register layout
   // ----------------------------------------------------------------
   localparam int PRECHARGE_BIT = 10;
   localparam int TERMINATION_STROBE_SEL_BIT = 11;
   localparam int CHOP_BIT = 12;
   localparam int MODE_REG_ONE = 1;
   localparam int NUM_MODE_REGS = 4;
   localparam int BURST_BEATS = 8;
   // ----------------------------------------------------------------
   // register map, fields and bus answers
   // ----------------------------------------------------------------
   localparam int AXI_AW = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LAST = 8'h08;
   localparam logic [7:0] REG_COUNT = 8'h0c;
   localparam logic [7:0] REG_MODE_BASE = 8'h10;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam int ST_TERMINATION_STROBE_BIT = 3;
   localparam int ST_TERM_BIT = 4;
   localparam int ST_BUSY_BIT = 5;
   localparam int LAST_BANK_LSB = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // power states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PWR_ON = 3'b001,
      PWR_DOWN = 3'b010,
      PWR_SREF = 3'b100
   } dca_pwr_t;
endpackage

// *** core/dca_sync.sv ***
// dca_sync: two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module dca_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins in, synchronised copy out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta;

   // first stage feeds the second stage only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= INIT;
         dout <= INIT;
      end else begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule // dca_sync
`default_nettype wire

// *** verification/dca_ctrl_model.sv ***
// dca_ctrl_model: controller model driving command, address, gate and mask pins
`timescale 1ns/1ns
`default_nettype none
module dca_ctrl_model (
   // clock
   input wire logic clk,
   // command and address pins
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [2:0] group_index,
   output logic [14:0] addr_lines,
   output logic clk_gate,
   // write mask pins
   output logic write_mask,
   output logic data_strobe
);
   // -------------------------------------------------------------
   // idle levels: deselected, gate open
   // -------------------------------------------------------------
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hf;
      group_index = 3'h0;
      addr_lines = 15'h0000;
      clk_gate = 1'b1;
      write_mask = 1'b0;
      data_strobe = 1'b0;
   end
   // one command cycle; released lines turn over so stale values never pass
   task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
      input logic g);
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= c;
      group_index <= b;
      addr_lines <= a;
      clk_gate <= g;
      @(posedge clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'hf;
      group_index <= ~b;
      addr_lines <= ~a;
   endtask
   // one strobe toggle with its mask bit, held two edges for the sync
   task automatic beat(input logic m);
      @(posedge clk);
      write_mask <= m;
      data_strobe <= ~data_strobe;
      repeat (2) @(posedge clk);
      write_mask <= ~m;
   endtask
endmodule // dca_ctrl_model
`default_nettype wire

// *** verification/tb.sv ***
// tb: self-checking bench of the command and address decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
   import dca_pkg::*;
   logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, te, cs_n, ras_n, cas_n, we_n, cg, wm, ds;
   logic act, rdp, wrp, pre, mld, refp, ap, pall, chop, bv, bk, tsm, ta;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic [2:0] gi, bank, msel, pst;
   logic [14:0] al, row, col, mop;
   logic [31:0] d;
   int fail_count, checks;
   dca_decoder i_dut (.CORE_CLK(clk), .RESETN(rst_n), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n),
      .GROUP_INDEX(gi), .ADDR_LINES(al), .CLK_GATE(cg), .TERMINATION_ENABLE(te),
      .WRITE_MASK(wm), .DATA_STROBE(ds), .CMD_ACT(act), .CMD_READ(rdp), .CMD_WRITE(wrp),
      .CMD_PRE(pre), .CMD_MODE_LOAD(mld), .CMD_REFRESH(refp), .CMD_BANK(bank),
      .ROW_ADDR(row), .COL_ADDR(col), .AUTO_PRECHARGE(ap), .PRECHARGE_ALL(pall),
      .CHOP_FLAG(chop), .MODE_SEL(msel), .MODE_OPCODE(mop), .BEAT_VALID(bv),
      .BEAT_KEEP(bk), .TERM_STROBE_MODE(tsm), .TERM_ACTIVE(ta), .POWER_STATE(pst));
   dca_ctrl_model i_ctrl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .group_index(gi), .addr_lines(al), .clk_gate(cg), .write_mask(wm),
      .data_strobe(ds));
   // -------------------------------------------------------------
   // clock, compare and closing
   // -------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // -------------------------------------------------------------
   // bus cycles: each channel held until its own ready
   // -------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata; r = rresp;
      rready <= 1'b0;
   endtask
   // one command through the model; pulses gathered over the answer window
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
      input logic g, input logic [5:0] e);
      logic [5:0] s;
      s = 6'h00;
      i_ctrl.issue(c, b, a, g);
      repeat (4) begin
         @(posedge clk); #1;
         s = s | {act, rdp, wrp, pre, mld, refp};
      end
      chk("cmd", e, s);
   endtask
   task automatic bt(input logic m, input logic ek);
      logic v, k;
      v = 1'b0; k = 1'bx;
      i_ctrl.beat(m);
      repeat (4) begin
         @(posedge clk); #1;
         if (bv === 1'b1) begin v = 1'b1; k = bk; end
      end
      chk("beat", 1, v);
      chk("keep", ek, k);
   endtask
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task automatic t_regs;
      rd(REG_CTRL); chk("ctrl", {31'h0, CTRL_EN_RESET}, d);
      rd(8'h40); chk("rresp", RESP_SLVERR, r); chk("rdata", 0, d);
      wr(8'h40, 32'h0000_0001); chk("bresp", RESP_SLVERR, r);
      wr(REG_CTRL, 32'h0000_0000); chk("bresp", RESP_OKAY, r);
      cmd(CMD_ACTIVATE, 3'h1, 15'h0011, 1'b1, 6'h00);
      wr(REG_CTRL, 32'h0000_0001);
      $display("t_regs done");
   endtask
   task automatic t_cmds;
      cmd(CMD_ACTIVATE, 3'h2, 15'h5a5a, 1'b1, 6'h20);
      chk("bank", 2, bank); chk("row", 15'h5a5a, row);
      cmd(CMD_READ, 3'h6, 15'h0413, 1'b1, 6'h10);
      chk("col", 15'h0413, col); chk("ap", 1, ap);
      cmd(CMD_WRITE, 3'h1, 15'h1008, 1'b1, 6'h08);
      chk("ap", 0, ap); chk("chop", 1, chop);
      cmd(CMD_PRECHARGE, 3'h3, 15'h0400, 1'b1, 6'h04); chk("all", 1, pall);
      cmd(CMD_PRECHARGE, 3'h5, 15'h0000, 1'b1, 6'h04); chk("all", 0, pall);
      chk("bank", 5, bank);
      cmd(CMD_REFRESH, 3'h0, 15'h0000, 1'b1, 6'h01);
      cmd(4'b0110, 3'h0, 15'h0000, 1'b1, 6'h00);
      cmd(4'b1011, 3'h2, 15'h0001, 1'b1, 6'h00); chk("row", 15'h5a5a, row);
      cmd(CMD_MODE_LOAD, 3'h1, 15'h0800, 1'b1, 6'h02);
      chk("msel", 1, msel); chk("mop", 15'h0800, mop);
      rd(REG_MODE_BASE + 8'h04); chk("mode1", 32'h0000_0800, d);
      rd(REG_LAST); chk("last", 32'h0005_5a5a, d);
      rd(REG_COUNT); chk("count", 32'h0000_0007, d);
      $display("t_cmds done");
   endtask
   task automatic t_mask;
      chk("tsm", 1, tsm);
      bt(1'b1, 1'b1);
      cmd(CMD_MODE_LOAD, 3'h1, 15'h0000, 1'b1, 6'h02); chk("tsm", 0, tsm);
      cmd(CMD_WRITE, 3'h0, 15'h0000, 1'b1, 6'h08);
      for (int i = 0; i < 4; i++) bt(i[0], ~i[0]);
      $display("t_mask done");
   endtask
   task automatic t_power;
      cmd(4'hf, 3'h0, 15'h0000, 1'b0, 6'h00); chk("pwr", PWR_DOWN, pst);
      chk("term", 1, ta);
      cmd(CMD_ACTIVATE, 3'h4, 15'h0022, 1'b0, 6'h00);
      cmd(4'hf, 3'h0, 15'h0000, 1'b1, 6'h00); chk("pwr", PWR_ON, pst);
      cmd(CMD_REFRESH, 3'h0, 15'h0000, 1'b0, 6'h00); chk("pwr", PWR_SREF, pst);
      chk("term", 0, ta);
      rd(REG_STATUS); chk("status", 32'h0000_0004, d);
      cmd(4'hf, 3'h0, 15'h0000, 1'b1, 6'h00); chk("pwr", PWR_ON, pst);
      // termination input must follow its pin while awake
      @(posedge clk);
      te <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("term", 0, ta);
      @(posedge clk);
      te <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("term", 1, ta);
      $display("t_power done");
   endtask
   // -------------------------------------------------------------
   // main sequence and watchdog
   // -------------------------------------------------------------
   initial begin
      rst_n = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0000_0000;
      wstrb = 4'hf; wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0;
      rready = 1'b0; te = 1'b1; fail_count = 0; checks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs;
      t_cmds;
      t_mask;
      t_power;
      give_verdict;
   end
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      give_verdict;
   end
endmodule // tb
`default_nettype wire
